// ### rtl/uart_ctl_regs.vh
`ifndef UART_CTL_REGS_VH
`define UART_CTL_REGS_VH
// Byte addresses of the registers on the APB port.
`define ADDR_DATA       12'h000
`define ADDR_ISR_FCR    12'h008
`define ADDR_LCR        12'h00C
`define ADDR_LSR        12'h014
`define ADDR_MSR        12'h018
`define ADDR_STATUS     12'h020
`define ADDR_DIV_LOW    12'h000
`define ADDR_DIV_HIGH   12'h004
`define ADDR_DIV_FRAC   12'h008
// Interrupt status codes, bits 5..0.
`define IRQ_NONE        6'h01
`define IRQ_LINE        6'h06
`define IRQ_RECEIVE_READY_IRQ       6'h04
`define IRQ_TIMEOUT     6'h0C
`define IRQ_TRANSMIT_READY_IRQ       6'h02
`define IRQ_MODEM       6'h00
`define IRQ_XCHAR       6'h10
`define IRQ_FLOWPIN     6'h20
// FIFO control fields.
`define FCR_ENABLE      0
`define FCR_RX_RESET    1
`define FCR_TX_RESET    2
`define FCR_DMA         3
// Line control fields.
`define LCR_PAR_EN      3
`define LCR_PAR_EVEN    4
`define LCR_PAR_FORCE   5
`define LCR_BREAK       6
`define LCR_DIV_SEL     7
`define LCR_RESET       8'h00
// Trigger tables.
`define RX_TRIG_0       6'd8
`define RX_TRIG_1       6'd16
`define RX_TRIG_2       6'd24
`define RX_TRIG_3       6'd28
`define TX_TRIG_0       6'd16
`define TX_TRIG_1       6'd8
`define TX_TRIG_2       6'd24
`define TX_TRIG_3       6'd30
// Receive time-out: four characters plus twelve bits.
`define TIMEOUT_CHARS   4
`define TIMEOUT_BITS    12
`endif

// ### rtl/uart_irq_fifo_line_control.v
// How it works
// - line status irq cleared by line status read
// - rx ready pending until count below trigger
// - time-out irq cleared by receive holding read
// - tx ready cleared by status read or write
// - modem irq cleared by modem status read
// - xoff irq cleared by status read or xon
// - special char cleared by read or next char
// - flow pin irqs cleared by modem status read
// - codes for priorities one to four
// - codes for priorities five to seven
// - no pending source reports code 000001
// - bit zero low while any source pending
// - bits 7:6 follow fifo enable
// - receive trigger table 8/16/24/28
// - transmit trigger 16/8/24/30 plus empty
// - rx trigger selected by bits 7:6, tx by bits 5:4
// - dma bit stored, no effect
// - tx fifo reset, self clearing
// - rx fifo reset, self clearing
// - fcr writes with bit zero clear only clear fifo enable
// - lcr bit 7 maps divisor registers
// - lcr bit 6 forces break on line
// - parity enable and odd/even select
// - forced parity mark or space
// - only highest pending source reported
// - time-out after 4 chars plus 12 bits
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "uart_ctl_regs.vh"
module uart_irq_fifo_line_control #(
   parameter CHAR_BITS = 10
)(
   input  wire        clk,
   input  wire        arst_n,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire [5:0]  rxCount,
   input  wire [5:0]  txCount,
   input  wire        bitTick,
   input  wire        rxActivity,
   input  wire        lineErrEvent,
   input  wire        modemDeltaEvent,
   input  wire        flowPinEvent,
   input  wire        xoffEvent,
   input  wire        xonEvent,
   input  wire        specialCharEvent,
   input  wire        charReceived,
   input  wire        txSerialIn,
   input  wire [7:0]  lineStatusIn,
   input  wire [7:0]  modemStatusIn,
   input  wire [7:0]  rxDataIn,
   output reg         txLine,
   output reg         rxFifoReset,
   output reg         txFifoReset,
   output reg         fifoEnable,
   output reg         dmaMode,
   output reg  [5:0]  rxTrigger,
   output reg  [5:0]  txTrigger,
   output reg         parityEnable,
   output reg         parityEven,
   output reg         parityForce,
   output reg         parityForcedValue,
   output reg         thrWriteStrobe,
   output reg  [7:0]  thrData,
   output reg  [7:0]  divisorLow,
   output reg  [7:0]  divisorHigh,
   output reg  [7:0]  divisorFraction,
   output reg         irqPending
);

   // Bit times of silence before a waiting character raises the time-out.
   // The count is in bit ticks, so the character length must match CHAR_BITS.

   localparam [15:0] TIMEOUT_TICKS = `TIMEOUT_CHARS * CHAR_BITS + `TIMEOUT_BITS;


   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode. Every access completes with no wait state.

   // Read data is captured in the setup cycle and presented with pready;
   // side effects of a read act at the access edge only, once per transfer.

   wire        access   = psel && penable;
   wire        wrAcc    = access && pwrite;
   wire        rdAcc    = access && !pwrite;
   wire        rdSetup  = psel && !penable && !pwrite;

   reg  [7:0]  line_control_reg;
   wire        divSel   = line_control_reg[`LCR_DIV_SEL];

   // Address hits. The data and status offsets are shared with the divisor
   // latches, so most strobes below are gated by the divisor select.

   wire        hitData  = paddr == `ADDR_DATA;
   wire        hitHigh  = paddr == `ADDR_DIV_HIGH;
   wire        hitIsr   = paddr == `ADDR_ISR_FCR;
   wire        hitLcr   = paddr == `ADDR_LCR;
   wire        hitLsr   = paddr == `ADDR_LSR;
   wire        hitMsr   = paddr == `ADDR_MSR;
   wire        hitStat  = paddr == `ADDR_STATUS;
   wire        mapped   = hitData || hitHigh || hitIsr || hitLcr || hitLsr || hitMsr || hitStat;

   // Strobes that clear interrupt sources or load data.

   wire        thrWrite = wrAcc && hitData && !divSel;
   wire        rhrRead  = rdAcc && hitData && !divSel;
   wire        isrRead  = rdAcc && hitIsr && !divSel;
   wire        lsrRead  = rdAcc && hitLsr;
   wire        msrRead  = rdAcc && hitMsr;
   wire        fcrWrite = wrAcc && hitIsr && !divSel && pwdata[`FCR_ENABLE];

   ////////////////////////////////////////////////////////////////////////////////
   // Sticky interrupt sources. A set in the same cycle as its clear wins.

   reg         lineIrq_reg;
   reg         timeoutIrq_reg;
   reg         txIrq_reg;
   reg         modemIrq_reg;
   reg         xoffIrq_reg;
   reg         specialIrq_reg;
   reg         flowIrq_reg;
   reg         specialWait_reg;
   reg         txAbove_reg;
   reg         txWasFull_reg;
   reg  [15:0] idleCount_reg;
   reg  [5:0]  isrCode;

   // Receive ready is a level, not a latch: it drops by itself once host
   // reads bring the count below the trigger.

   wire        rxIrq    = fifoEnable ? (rxCount >= rxTrigger) : (rxCount != 6'd0);

   wire        txBelow  = fifoEnable ? (txCount < txTrigger) : (txCount == 6'd0);

   wire        txEmpty  = txCount == 6'd0;

   // Transmit ready event: crossing below the trigger, or emptying without a crossing.
   // Without the history bit an idle empty FIFO would raise it again after every clear.

   wire        txEvent  = (txAbove_reg && txBelow) || (txEmpty && !txAbove_reg && !txIrq_reg
                          && txWasFull_reg);

   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         lineIrq_reg     <= 1'b0;
         timeoutIrq_reg  <= 1'b0;
         txIrq_reg       <= 1'b0;
         modemIrq_reg    <= 1'b0;
         xoffIrq_reg     <= 1'b0;
         specialIrq_reg  <= 1'b0;
         flowIrq_reg     <= 1'b0;
         specialWait_reg <= 1'b0;
         txAbove_reg     <= 1'b0;
         txWasFull_reg   <= 1'b0;
         idleCount_reg   <= 16'h0000;
      end
      else
      begin
         lineIrq_reg   <= lineErrEvent || (lineIrq_reg && !lsrRead);

         modemIrq_reg  <= modemDeltaEvent || (modemIrq_reg && !msrRead);

         flowIrq_reg   <= flowPinEvent || (flowIrq_reg && !msrRead);

         xoffIrq_reg   <= xoffEvent || (xoffIrq_reg && !isrRead && !xonEvent);

         // The special character itself is not the "next" character.
         specialIrq_reg  <= specialCharEvent ||
                            (specialIrq_reg && !isrRead && !(charReceived && specialWait_reg));
         specialWait_reg <= specialCharEvent ? 1'b0 :
                            (specialIrq_reg ? 1'b1 : 1'b0);

         txIrq_reg     <= txEvent || (txIrq_reg && !isrRead && !thrWrite);

         txAbove_reg   <= fifoEnable && !txBelow;

         txWasFull_reg <= txEmpty ? 1'b0 : 1'b1;

         // Time-out counts bit times of silence while data waits.
         // The counter saturates so that a stalled host sees one event only.
         if (rxCount == 6'd0 || rxActivity || rhrRead)
            idleCount_reg <= 16'h0000;
         else if (bitTick && idleCount_reg != TIMEOUT_TICKS)
            idleCount_reg <= idleCount_reg + 16'h0001;

         timeoutIrq_reg <= (bitTick && idleCount_reg == TIMEOUT_TICKS - 16'h0001
                            && rxCount != 6'd0 && !rxActivity)
                           || (timeoutIrq_reg && !rhrRead);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Priority encoder: only the highest pending source is visible.

   always @*
   begin
      if (lineIrq_reg)
         isrCode = `IRQ_LINE;
      else if (rxIrq)
         isrCode = `IRQ_RECEIVE_READY_IRQ;
      else if (timeoutIrq_reg)
         isrCode = `IRQ_TIMEOUT;
      else if (txIrq_reg)
         isrCode = `IRQ_TRANSMIT_READY_IRQ;
      else if (modemIrq_reg)
         isrCode = `IRQ_MODEM;
      else if (xoffIrq_reg || specialIrq_reg)
         isrCode = `IRQ_XCHAR;
      else if (flowIrq_reg)
         isrCode = `IRQ_FLOWPIN;
      else
         isrCode = `IRQ_NONE;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control registers and bus answer.

   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         line_control_reg  <= `LCR_RESET;
         fifoEnable        <= 1'b0;
         dmaMode           <= 1'b0;
         rxTrigger         <= `RX_TRIG_0;
         txTrigger         <= `TX_TRIG_0;
         rxFifoReset       <= 1'b0;
         txFifoReset       <= 1'b0;
         divisorLow        <= 8'h00;
         divisorHigh       <= 8'h00;
         divisorFraction   <= 8'h00;
         thrWriteStrobe    <= 1'b0;
         thrData           <= 8'h00;
         prdata            <= 32'h0000_0000;
         pready            <= 1'b0;
         pslverr           <= 1'b0;
         txLine            <= 1'b1;
         parityEnable      <= 1'b0;
         parityEven        <= 1'b0;
         parityForce       <= 1'b0;
         parityForcedValue <= 1'b1;
         irqPending        <= 1'b0;
      end
      else
      begin
         // Every access answers in its first access cycle.
         pready         <= psel && !penable;

         pslverr        <= psel && !penable && !mapped;

         thrWriteStrobe <= thrWrite && pready;

         // Reset pulses last exactly one cycle after the write.
         rxFifoReset    <= fcrWrite && pready && fifoEnable && pwdata[`FCR_RX_RESET];

         txFifoReset    <= fcrWrite && pready && fifoEnable && pwdata[`FCR_TX_RESET];

         if (thrWrite && pready)
            thrData <= pwdata[7:0];

         if (fcrWrite && pready)
         begin
            fifoEnable <= 1'b1;
            dmaMode    <= pwdata[`FCR_DMA];
            // Each direction has its own selection: bits 7:6 for receive, 5:4 for transmit.
            case (pwdata[7:6])
               2'b00:   rxTrigger <= `RX_TRIG_0;
               2'b01:   rxTrigger <= `RX_TRIG_1;
               2'b10:   rxTrigger <= `RX_TRIG_2;
               default: rxTrigger <= `RX_TRIG_3;
            endcase
            case (pwdata[5:4])
               2'b00:   txTrigger <= `TX_TRIG_0;
               2'b01:   txTrigger <= `TX_TRIG_1;
               2'b10:   txTrigger <= `TX_TRIG_2;
               default: txTrigger <= `TX_TRIG_3;
            endcase
         end
         else if (wrAcc && pready && hitIsr && !divSel)
            fifoEnable <= 1'b0;

         if (wrAcc && pready && hitLcr)
            line_control_reg <= pwdata[7:0];

         if (wrAcc && pready && divSel)
         begin
            if (hitData)
               divisorLow <= pwdata[7:0];
            if (hitHigh)
               divisorHigh <= pwdata[7:0];
            if (hitIsr)
               divisorFraction <= pwdata[7:0];
         end
         // Read data stands for the access cycle only and is zero otherwise.
         prdata <= 32'h0000_0000;

         if (rdSetup)
         begin

            if (hitData)
            begin
               prdata <= {24'h00_0000, divSel ? divisorLow : rxDataIn};
            end

            else if (hitHigh && divSel)
            begin
               prdata <= {24'h00_0000, divisorHigh};
            end

            else if (hitIsr)
            begin
               // The code is snapshot here; a later source waits for the next read, but tx ready, xoff and special char set in the setup cycle are lost.
               prdata <= {24'h00_0000, divSel ? divisorFraction
                          : {{2{fifoEnable}}, isrCode}};
            end

            else if (hitLcr)
            begin
               prdata <= {24'h00_0000, line_control_reg};
            end

            else if (hitLsr)
            begin
               prdata <= {24'h00_0000, lineStatusIn};
            end

            else if (hitMsr)
            begin
               prdata <= {24'h00_0000, modemStatusIn};
            end

            else if (hitStat)
            begin
               prdata <= {25'h000_0000, lineIrq_reg, timeoutIrq_reg, txIrq_reg,
                          modemIrq_reg, xoffIrq_reg, specialIrq_reg, flowIrq_reg};
            end

         end

         // Line format outputs follow the control register one cycle later.

         txLine            <= line_control_reg[`LCR_BREAK] ? 1'b0 : txSerialIn;

         parityEnable      <= line_control_reg[`LCR_PAR_EN];

         parityEven        <= line_control_reg[`LCR_PAR_EVEN];

         parityForce       <= line_control_reg[`LCR_PAR_EN] && line_control_reg[`LCR_PAR_FORCE];

         parityForcedValue <= !line_control_reg[`LCR_PAR_EVEN];

         irqPending        <= isrCode != `IRQ_NONE;

      end
   end

endmodule

// ### test/apb_host_model.sv
`timescale 1ns/1ps
module apb_host_model (
   input  wire        clk,
   output reg         psel = 1'b0,
   output reg         penable = 1'b0,
   output reg         pwrite = 1'b0,
   output reg  [11:0] paddr = 12'h000,
   output reg  [31:0] pwdata = 32'h0000_0000,
   input  wire [31:0] prdata,
   input  wire        pready,
   input  wire        pslverr
);
   // Idle address and data are inverted so stale values never look like a live request.
   task automatic xfer(input bit w, input [11:0] a, input [31:0] d, output [31:0] r,
                       output e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule

// ### test/tb.sv
`timescale 1ns/1ps
`include "uart_ctl_regs.vh"
module tb;
   reg         clk = 1'b0;
   reg         arst_n = 1'b0;
   reg  [5:0]  rxCount = 6'h00;
   reg  [5:0]  txCount = 6'h1f;
   reg         bitTick = 1'b0;
   reg  [6:0]  ev = 7'h00;
   reg         txSerialIn = 1'b1;
   reg  [23:0] stat = 24'h00_0000;
   reg         err;
   wire        psel, penable, pwrite, pready, pslverr, txLine, fifoEnable, dmaMode, irqPending;
   wire        parityEnable, parityEven, parityForce, parityForcedValue;
   wire [11:0] paddr;
   wire [31:0] pwdata, prdata;
   wire [5:0]  rxTrigger, txTrigger;
   wire [7:0]  thrData, divisorLow, divisorHigh, divisorFraction;
   integer     bad_count = 0;
   integer     num_checks = 0;
   int         pend = 0;
   bit         fe = 1'b0;
   localparam [41:0] CODES = {`IRQ_FLOWPIN, `IRQ_XCHAR, `IRQ_MODEM, `IRQ_TRANSMIT_READY_IRQ, `IRQ_TIMEOUT,
                              `IRQ_RECEIVE_READY_IRQ, `IRQ_LINE};
   localparam [23:0] RXT = {`RX_TRIG_3, `RX_TRIG_2, `RX_TRIG_1, `RX_TRIG_0};
   localparam [23:0] TXT = {`TX_TRIG_3, `TX_TRIG_2, `TX_TRIG_1, `TX_TRIG_0};
   always #2 clk = ~clk;
   apb_host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   uart_irq_fifo_line_control #(.CHAR_BITS(2)) dut (.clk(clk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rxCount(rxCount), .txCount(txCount),
      .bitTick(bitTick), .rxActivity(1'b0), .lineErrEvent(ev[0]), .modemDeltaEvent(ev[1]),
      .flowPinEvent(ev[2]), .xoffEvent(ev[3]), .xonEvent(ev[4]), .specialCharEvent(ev[5]),
      .charReceived(ev[6]), .txSerialIn(txSerialIn), .lineStatusIn(stat[7:0]),
      .modemStatusIn(stat[15:8]), .rxDataIn(stat[23:16]), .txLine(txLine), .rxFifoReset(),
      .txFifoReset(), .fifoEnable(fifoEnable), .dmaMode(dmaMode), .rxTrigger(rxTrigger),
      .txTrigger(txTrigger), .parityEnable(parityEnable), .parityEven(parityEven),
      .parityForce(parityForce), .parityForcedValue(parityForcedValue), .thrWriteStrobe(),
      .thrData(thrData),
      .divisorLow(divisorLow), .divisorHigh(divisorHigh), .divisorFraction(divisorFraction),
      .irqPending(irqPending));
   ////////////////////////////////////////////////////////////
   // The model reports the highest pending source, so the lowest index wins.
   function automatic [7:0] isrExp();
      isrExp = {fe, fe, `IRQ_NONE};
      for (int i = 6; i >= 0; i--)
         if (pend[i])
            isrExp[5:0] = CODES[i*6 +: 6];
   endfunction
   task chk(input string what, input [31:0] exp, input [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task rd(input [11:0] a, output [31:0] r);
      host.xfer(1'b0, a, 32'h0000_0000, r, err);
   endtask
   // Two edges pass so that registered outputs of the write have settled.
   task wr(input [11:0] a, input [31:0] d);
      reg [31:0] r;
      host.xfer(1'b1, a, d, r, err);
      repeat (2) @(posedge clk);
   endtask
   task interrupt_status();
      reg [31:0] r;
      rd(`ADDR_ISR_FCR, r);
      chk("isr", isrExp(), r);
      pend = pend & ~40;
   endtask
   task evt(input [6:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 7'h00;
   endtask
   task tally_and_finish();
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      tally_and_finish();
   end
   initial
   begin
      reg [31:0] v, r;
      void'($urandom(11882));
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      stat <= $urandom;
      interrupt_status();
      wr(`ADDR_ISR_FCR, 32'h0000_00c6);
      chk("fifoEnable", 0, fifoEnable);
      chk("rxTrigger", `RX_TRIG_0, rxTrigger);
      for (int i = 0; i < 4; i++)
      begin
         v = $urandom & 32'h0000_00f9 | 32'h0000_0001;
         v[7:6] = i[1:0];
         wr(`ADDR_ISR_FCR, v);
         chk("rxTrigger", RXT[v[7:6]*6 +: 6], rxTrigger);
         chk("txTrigger", TXT[v[5:4]*6 +: 6], txTrigger);
         chk("dmaMode", v[3], dmaMode);
      end
      fe = 1'b1;
      wr(`ADDR_ISR_FCR, v | 32'h0000_0006);
      wr(`ADDR_ISR_FCR, 32'h0000_0001);
      interrupt_status();
      evt(7'h05);
      pend = 65;
      interrupt_status();
      rd(`ADDR_LSR, r);
      chk("lsr", stat[7:0], r);
      pend = 64;
      interrupt_status();
      evt(7'h02);
      pend = 80;
      interrupt_status();
      rd(`ADDR_MSR, r);
      chk("msr", stat[15:8], r);
      pend = 0;
      interrupt_status();
      txCount <= 6'd10;
      pend = 8;
      interrupt_status();
      interrupt_status();
      txCount <= 6'h1f;
      @(posedge clk);
      txCount <= 6'd4;
      repeat (3) @(posedge clk);
      chk("irqPending", 1, irqPending);
      wr(`ADDR_DATA, v);
      chk("thrData", v[7:0], thrData);
      chk("irqPending", 0, irqPending);
      rxCount <= 6'd8;
      pend = 2;
      interrupt_status();
      rd(`ADDR_DATA, r);
      chk("rhr", stat[23:16], r);
      interrupt_status();
      rxCount <= 6'd7;
      pend = 0;
      interrupt_status();
      repeat (48) @(posedge clk) bitTick <= ~bitTick;
      pend = 4;
      interrupt_status();
      rd(`ADDR_DATA, r);
      pend = 0;
      interrupt_status();
      rxCount <= 6'h00;
      evt(7'h08);
      pend = 32;
      interrupt_status();
      interrupt_status();
      evt(7'h08);
      evt(7'h10);
      interrupt_status();
      evt(7'h60);
      evt(7'h40);
      interrupt_status();
      for (int i = 0; i < 6; i++)
      begin
         v = $urandom;
         txSerialIn <= v[31];
         v = v & 32'h0000_007f;
         v[6] = i[0];
         wr(`ADDR_LCR, v);
         rd(`ADDR_LCR, r);
         chk("lcr", v[7:0], r);
         chk("parityEnable", v[3], parityEnable);
         chk("parityEven", v[4], parityEven);
         chk("parityForce", v[5] & v[3], parityForce);
         chk("parityForcedValue", !v[4], parityForcedValue);
         chk("txLine", v[6] ? 1'b0 : txSerialIn, txLine);
      end
      wr(`ADDR_LCR, 32'h0000_0080);
      wr(`ADDR_DIV_LOW, 32'h0000_005a);
      wr(`ADDR_DIV_HIGH, 32'h0000_00a5);
      wr(`ADDR_DIV_FRAC, 32'h0000_00c1);
      chk("divisorLow", 8'h5a, divisorLow);
      chk("divisorHigh", 8'ha5, divisorHigh);
      chk("divisorFraction", 8'hc1, divisorFraction);
      chk("rxTrigger", `RX_TRIG_0, rxTrigger);
      wr(`ADDR_LCR, 32'h0000_0000);
      rd(12'h030, r);
      chk("pslverr", 1, err);
      tally_and_finish();
   end
endmodule

// ### test/uart_ctl_monitor.sv
`timescale 1ns/1ps
`include "uart_ctl_regs.vh"
module uart_ctl_monitor #(
   parameter CHAR_BITS = 10
)(
   input wire        clk,
   input wire        arst_n,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        fifoEnable,
   input wire [5:0]  rxTrigger,
   input wire [5:0]  txTrigger,
   input wire        rxFifoReset,
   input wire        txFifoReset,
   input wire        txLine,
   input wire        parityEnable,
   input wire        parityEven,
   input wire        parityForce,
   input wire        parityForcedValue
);
   localparam [23:0] RXT = {`RX_TRIG_3, `RX_TRIG_2, `RX_TRIG_1, `RX_TRIG_0};
   localparam [23:0] TXT = {`TX_TRIG_3, `TX_TRIG_2, `TX_TRIG_1, `TX_TRIG_0};
   // The divisor select is tracked here because the shared offsets change meaning with it.
   reg  divSel;
   wire wrAcc = psel && penable && pready && pwrite;
   wire fcrWr = wrAcc && paddr == `ADDR_ISR_FCR && !divSel;
   wire lcrWr = wrAcc && paddr == `ADDR_LCR;
   wire isrRd = psel && penable && pready && !pwrite && paddr == `ADDR_ISR_FCR && !divSel;
   always @(posedge clk or negedge arst_n)
      if (!arst_n)
         divSel <= 1'b0;
      else if (lcrWr)
         divSel <= pwdata[7];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_none; isrRd && prdata[0] |-> prdata[5:1] == 5'h00; endproperty
   a_none: assert property (p_none) else $error("idle code wrong");
   property p_fifo_bits; isrRd |-> prdata[7:6] == {2{fifoEnable}}; endproperty
   a_fifo_bits: assert property (p_fifo_bits) else $error("fifo status bits wrong");
   property p_rx_trig; fcrWr && pwdata[0] |=> rxTrigger == RXT[$past(pwdata[7:6])*6 +: 6];
   endproperty
   a_rx_trig: assert property (p_rx_trig) else $error("rx trigger wrong");
   property p_tx_trig; fcrWr && pwdata[0] |=> txTrigger == TXT[$past(pwdata[5:4])*6 +: 6];
   endproperty
   a_tx_trig: assert property (p_tx_trig) else $error("tx trigger wrong");
   property p_ignore; fcrWr && !pwdata[0] |=> !fifoEnable && $stable(rxTrigger); endproperty
   a_ignore: assert property (p_ignore) else $error("disabled write not ignored");
   property p_rx_rst; fcrWr && pwdata[0] && pwdata[1] && fifoEnable |-> ##[1:2] rxFifoReset;
   endproperty
   a_rx_rst: assert property (p_rx_rst) else $error("rx fifo reset missing");
   property p_tx_rst; fcrWr && pwdata[0] && pwdata[2] && fifoEnable |-> ##[1:2] txFifoReset;
   endproperty
   a_tx_rst: assert property (p_tx_rst) else $error("tx fifo reset missing");
   property p_rst_pulse; rxFifoReset || txFifoReset |=> !rxFifoReset && !txFifoReset;
   endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
   property p_break; lcrWr && pwdata[6] |-> ##[1:2] !txLine; endproperty
   a_break: assert property (p_break) else $error("break not driven");
   property p_parity; lcrWr |-> ##2 parityEnable == $past(pwdata[3], 2)
      && parityEven == $past(pwdata[4], 2);
   endproperty
   a_parity: assert property (p_parity) else $error("parity format wrong");
   property p_force; parityForce |-> parityForcedValue == !parityEven; endproperty
   a_force: assert property (p_force) else $error("forced parity wrong");
   cover property (isrRd && prdata[5:0] == `IRQ_TIMEOUT);
   cover property (rxFifoReset && txFifoReset);
   cover property (lcrWr && pwdata[7]);
endmodule
bind uart_irq_fifo_line_control uart_ctl_monitor #(.CHAR_BITS(CHAR_BITS)) mon (.*);
